/* hdl/ilc_loop_code.sv */
// In-band loop code generator and three detectors with Wishbone registers
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
module ilc_loop_code #(
    parameter int unsigned INTEG_CYCLES = ilc_pkg::INTEG_CYCLES,
    parameter int unsigned WIN_BITS = ilc_pkg::WIN_BITS,
    parameter int unsigned WIN_MAX_ERR = ilc_pkg::WIN_MAX_ERR
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [3:0] wb_sel_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    input wire ilc_pkg::ilc_line_t tx_line_in,
    input wire ilc_pkg::ilc_line_t rx_line_in,
    output logic tx_data_out,
    output logic loop_up_detected_out,
    output logic loop_down_detected_out,
    output logic spare_code_detected_out
);
    localparam int CW = $clog2(INTEG_CYCLES + 1);
    localparam int WW = $clog2(WIN_BITS + 1);
    localparam logic [CW-1:0] INTEG_LAST = CW'(INTEG_CYCLES - 1);
    localparam logic [WW-1:0] WIN_LAST = WW'(WIN_BITS - 1);
    localparam logic [WW-1:0] ERR_MAX = WW'(WIN_MAX_ERR);

    if (INTEG_CYCLES < 2 || WIN_BITS < 16 || WIN_MAX_ERR >= WIN_BITS) begin : g_chk
        $error("ilc_loop_code: unusable parameter values");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_m_q;
    logic rst_n;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_m_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n <= rst_m_q;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic [7:0] inband_code_control_q;
    logic [7:0] tx_code_def_hi_q;
    logic [7:0] tx_code_def_lo_q;
    logic [7:0] rx_code_hi_q [0:2];
    logic [7:0] rx_code_lo_q [0:2];
    logic [7:0] rx_spare_code_control_q;
    logic [7:0] t1_common_control_1_q;
    logic [2:0] det_q;
    logic [7:0] status_reg_three;
    logic [7:0] idx;
    logic req;
    logic wr;
    logic [2:0] restart;

    assign idx = wb_adr_in[9:2];
    assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr = req & wb_we_in & wb_sel_in[0];
    always_comb begin
        status_reg_three = 8'h00;
        status_reg_three[ilc_pkg::UP_DET_BIT] = det_q[0];
        status_reg_three[ilc_pkg::DOWN_DET_BIT] = det_q[1];
        status_reg_three[ilc_pkg::SPARE_DET_BIT] = det_q[2];
    end

    // Either code byte of a detector restarts its integration
    assign restart[0] = wr & (idx == ilc_pkg::IDX_UP_HI || idx == ilc_pkg::IDX_UP_LO);
    assign restart[1] = wr & (idx == ilc_pkg::IDX_DN_HI || idx == ilc_pkg::IDX_DN_LO);
    assign restart[2] = wr & (idx == ilc_pkg::IDX_SP_HI || idx == ilc_pkg::IDX_SP_LO);

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= req;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (req && !wb_we_in) begin
            unique case (idx)
                ilc_pkg::IDX_INBAND_CTRL: wb_dat_out <= {24'h0, inband_code_control_q};
                ilc_pkg::IDX_TCD_HI: wb_dat_out <= {24'h0, tx_code_def_hi_q};
                ilc_pkg::IDX_TCD_LO: wb_dat_out <= {24'h0, tx_code_def_lo_q};
                ilc_pkg::IDX_UP_HI: wb_dat_out <= {24'h0, rx_code_hi_q[0]};
                ilc_pkg::IDX_UP_LO: wb_dat_out <= {24'h0, rx_code_lo_q[0]};
                ilc_pkg::IDX_DN_HI: wb_dat_out <= {24'h0, rx_code_hi_q[1]};
                ilc_pkg::IDX_DN_LO: wb_dat_out <= {24'h0, rx_code_lo_q[1]};
                ilc_pkg::IDX_SP_HI: wb_dat_out <= {24'h0, rx_code_hi_q[2]};
                ilc_pkg::IDX_SP_LO: wb_dat_out <= {24'h0, rx_code_lo_q[2]};
                ilc_pkg::IDX_SP_CTRL: wb_dat_out <= {24'h0, rx_spare_code_control_q};
                ilc_pkg::IDX_CCR1: wb_dat_out <= {24'h0, t1_common_control_1_q};
                ilc_pkg::IDX_STATUS3: wb_dat_out <= {24'h0, status_reg_three};
                default: wb_dat_out <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            inband_code_control_q <= ilc_pkg::REG_RST;
            tx_code_def_hi_q <= ilc_pkg::REG_RST;
            tx_code_def_lo_q <= ilc_pkg::REG_RST;
            rx_spare_code_control_q <= ilc_pkg::REG_RST;
            t1_common_control_1_q <= ilc_pkg::REG_RST;
            for (int i = 0; i < 3; i++) begin
                rx_code_hi_q[i] <= ilc_pkg::REG_RST;
                rx_code_lo_q[i] <= ilc_pkg::REG_RST;
            end
        end else if (wr) begin
            unique case (idx)
                ilc_pkg::IDX_INBAND_CTRL: inband_code_control_q <= wb_dat_in[7:0];
                ilc_pkg::IDX_TCD_HI: tx_code_def_hi_q <= wb_dat_in[7:0];
                ilc_pkg::IDX_TCD_LO: tx_code_def_lo_q <= wb_dat_in[7:0];
                ilc_pkg::IDX_UP_HI: rx_code_hi_q[0] <= wb_dat_in[7:0];
                ilc_pkg::IDX_UP_LO: rx_code_lo_q[0] <= wb_dat_in[7:0];
                ilc_pkg::IDX_DN_HI: rx_code_hi_q[1] <= wb_dat_in[7:0];
                ilc_pkg::IDX_DN_LO: rx_code_lo_q[1] <= wb_dat_in[7:0];
                ilc_pkg::IDX_SP_HI: rx_code_hi_q[2] <= wb_dat_in[7:0];
                ilc_pkg::IDX_SP_LO: rx_code_lo_q[2] <= wb_dat_in[7:0];
                ilc_pkg::IDX_SP_CTRL: rx_spare_code_control_q <= wb_dat_in[7:0];
                ilc_pkg::IDX_CCR1: t1_common_control_1_q <= wb_dat_in[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Generator
    // ------------------------------------------------------------
    logic t1_on;
    logic tx_on;
    logic tx_fslot;
    logic [15:0] tx_pat;
    logic [4:0] tx_len;
    logic [3:0] tx_phase_q;

    assign t1_on = t1_common_control_1_q[ilc_pkg::T1_MODE_BIT];
    assign tx_on = t1_on & t1_common_control_1_q[ilc_pkg::TX_LOOP_EN_BIT];
    assign tx_fslot = tx_line_in.fbit & ~t1_common_control_1_q[ilc_pkg::FBIT_OFF_BIT];
    assign tx_pat = {tx_code_def_hi_q, tx_code_def_lo_q};

    always_comb begin
        unique case (inband_code_control_q[ilc_pkg::TX_LEN_LSB +: 2])
            2'h0: tx_len = 5'h05;
            2'h1: tx_len = 5'h06;
            2'h2: tx_len = 5'h07;
            2'h3: tx_len = ilc_pkg::LEN_16;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_phase_q <= 4'h0;
            tx_data_out <= 1'b0;
        end else if (!tx_on) begin
            // Phase clears without waiting for a strobe, so every run starts at the top bit
            tx_phase_q <= 4'h0;
            if (tx_line_in.en) begin
                tx_data_out <= tx_line_in.data;
            end
        end else if (tx_line_in.en) begin
            // An F slot overwrites a pattern bit, so the phase still moves on
            tx_data_out <= tx_fslot ? tx_line_in.data : tx_pat[4'hf - tx_phase_q];
            tx_phase_q <= (5'(tx_phase_q) == tx_len - 5'h01) ? 4'h0 : tx_phase_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Detectors: 0 up, 1 down, 2 spare
    // ------------------------------------------------------------
    function automatic logic pat_match(logic [15:0] h, logic [15:0] p, logic [4:0] l);
        logic m;
        m = 1'b1;
        for (int k = 0; k < 16; k++) begin
            if (k < int'(l) && h[int'(l) - 1 - k] != p[15 - k]) begin
                m = 1'b0;
            end
        end
        return m;
    endfunction

    logic [2:0] len_code [0:2];
    assign len_code[0] = inband_code_control_q[ilc_pkg::UP_LEN_LSB +: 3];
    assign len_code[1] = inband_code_control_q[ilc_pkg::DN_LEN_LSB +: 3];
    assign len_code[2] = rx_spare_code_control_q[ilc_pkg::SP_LEN_LSB +: 3];

    logic [CW-1:0] icnt_q [0:2];

    for (genvar d = 0; d < 3; d++) begin : g_det
        logic [4:0] len;
        logic [15:0] pat;
        logic run;
        logic [1:0] good;
        // Code 7 always runs 16 bits: equal bytes make that an 8-bit code
        assign len = (len_code[d] == ilc_pkg::LEN_WIDE) ? ilc_pkg::LEN_16 : 5'(len_code[d]) + 5'h01;
        assign pat = {rx_code_hi_q[d], rx_code_lo_q[d]};
        assign run = t1_on & ~restart[d];

        // Tracker 0 drops F slots (inserted), tracker 1 fills them with the expected bit
        for (genvar v = 0; v < 2; v++) begin : g_trk
            logic [15:0] hist_q;
            logic [15:0] hist_d;
            logic [3:0] phase_q;
            logic [WW-1:0] bcnt_q;
            logic [WW-1:0] ecnt_q;
            logic good_q;
            logic exp_bit;
            logic take;
            logic cmp;
            logic err;
            always_comb begin
                exp_bit = pat[4'hf - phase_q];
                cmp = rx_line_in.en & ~rx_line_in.fbit;
                take = rx_line_in.en & (~rx_line_in.fbit | (v == 1));
                err = cmp & (rx_line_in.data != exp_bit);
                hist_d = {hist_q[14:0], rx_line_in.fbit ? exp_bit : rx_line_in.data};
            end
            always_ff @(posedge clock_in or negedge rst_n) begin
                if (!rst_n) begin
                    hist_q <= 16'h0000;
                    phase_q <= 4'h0;
                end else if (!run) begin
                    hist_q <= 16'h0000;
                    phase_q <= 4'h0;
                end else if (take) begin
                    hist_q <= hist_d;
                    // A clean copy of the code in history realigns the phase
                    if (pat_match(hist_d, pat, len) || 5'(phase_q) == len - 5'h01) begin
                        phase_q <= 4'h0;
                    end else begin
                        phase_q <= phase_q + 4'h1;
                    end
                end
            end
            always_ff @(posedge clock_in or negedge rst_n) begin
                if (!rst_n) begin
                    bcnt_q <= '0;
                    ecnt_q <= '0;
                    good_q <= 1'b0;
                end else if (!run) begin
                    bcnt_q <= '0;
                    ecnt_q <= '0;
                    good_q <= 1'b0;
                end else if (cmp) begin
                    if (bcnt_q == WIN_LAST) begin
                        good_q <= (ecnt_q + WW'(err)) <= ERR_MAX;
                        bcnt_q <= '0;
                        ecnt_q <= '0;
                    end else begin
                        bcnt_q <= bcnt_q + WW'(1);
                        ecnt_q <= ecnt_q + WW'(err);
                    end
                end
            end
            assign good[v] = good_q;
        end

        // Status is live: it falls as soon as the windows of both trackers fail
        always_ff @(posedge clock_in or negedge rst_n) begin
            if (!rst_n) begin
                icnt_q[d] <= '0;
                det_q[d] <= 1'b0;
            end else if (!run || good == 2'b00) begin
                icnt_q[d] <= '0;
                det_q[d] <= 1'b0;
            end else if (icnt_q[d] == INTEG_LAST) begin
                det_q[d] <= 1'b1;
            end else begin
                icnt_q[d] <= icnt_q[d] + CW'(1);
            end
        end
    end

    assign loop_up_detected_out = det_q[0];
    assign loop_down_detected_out = det_q[1];
    assign spare_code_detected_out = det_q[2];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held for more than one cycle");
    ack_next_cycle_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack not given one cycle after request");
    tx_passthru_a: assert property (tx_line_in.en && !tx_on |=>
        tx_data_out == $past(tx_line_in.data))
        else $error("transmit data altered outside loop mode");
    tx_first_bit_a: assert property (tx_line_in.en && tx_on && !tx_fslot
        && tx_phase_q == 4'h0 |=> tx_data_out == $past(tx_code_def_hi_q[7]))
        else $error("first pattern bit is not the top code bit");
    tx_fbit_slot_a: assert property (tx_line_in.en && tx_on && tx_fslot
        |=> tx_data_out == $past(tx_line_in.data))
        else $error("framing bit not placed in its slot");
    tx_len_wrap_a: assert property (tx_line_in.en && tx_on
        && 5'(tx_phase_q) == tx_len - 5'h01 |=> tx_phase_q == 4'h0)
        else $error("transmit pattern length wrong");
    non_t1_clear_a: assert property (!t1_on |=> det_q == 3'b000)
        else $error("detect status set outside T1");
    restart_clear_a: assert property (restart[0] |=> !det_q[0] && icnt_q[0] == '0)
        else $error("code write did not restart integration");
    integ_time_a: assert property ($rose(det_q[1]) |-> $past(icnt_q[1]) == INTEG_LAST)
        else $error("down status rose before integration period");
    sr3_read_a: assert property (req && !wb_we_in && idx == ilc_pkg::IDX_STATUS3
        |=> wb_dat_out[7:5] == $past(det_q))
        else $error("status bits misplaced in status register");

    up_seen_c: cover property ($rose(det_q[0]));
    spare_seen_c: cover property ($rose(det_q[2]));
    tx_run_c: cover property (tx_on && tx_line_in.en && tx_fslot);
    up_lost_c: cover property ($fell(det_q[0]) && t1_on);
endmodule

/* hdl/ilc_pkg.sv */
// Constants and carrier types of the in-band loop code unit
package ilc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned INTEG_MS = 36;
    localparam int unsigned INTEG_CYCLES = INTEG_MS * 1000 * CLK_MHZ;
    // Error window: 2 of 128 tolerates a 1e-2 error rate with margin
    localparam int unsigned WIN_BITS = 128;
    localparam int unsigned WIN_MAX_ERR = 2;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_INBAND_CTRL = 8'hb6;
    localparam logic [7:0] IDX_TCD_HI = 8'hb7;
    localparam logic [7:0] IDX_TCD_LO = 8'hb8;
    localparam logic [7:0] IDX_UP_HI = 8'hb9;
    localparam logic [7:0] IDX_UP_LO = 8'hba;
    localparam logic [7:0] IDX_DN_HI = 8'hbb;
    localparam logic [7:0] IDX_DN_LO = 8'hbc;
    localparam logic [7:0] IDX_SP_HI = 8'hbd;
    localparam logic [7:0] IDX_SP_LO = 8'hbe;
    localparam logic [7:0] IDX_SP_CTRL = 8'hbf;
    localparam logic [7:0] IDX_CCR1 = 8'hc0;
    localparam logic [7:0] IDX_STATUS3 = 8'hc1;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned DN_LEN_LSB = 0;
    localparam int unsigned UP_LEN_LSB = 3;
    localparam int unsigned TX_LEN_LSB = 6;
    localparam int unsigned SP_LEN_LSB = 0;
    localparam int unsigned TX_LOOP_EN_BIT = 0;
    localparam int unsigned T1_MODE_BIT = 1;
    localparam int unsigned FBIT_OFF_BIT = 2;
    localparam int unsigned UP_DET_BIT = 5;
    localparam int unsigned DOWN_DET_BIT = 6;
    localparam int unsigned SPARE_DET_BIT = 7;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [2:0] LEN_WIDE = 3'h7;
    localparam logic [4:0] LEN_16 = 5'h10;
    // ------------------------------------------------------------
    // Line bit carrier from the framer
    // ------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic fbit;
        logic data;
    } ilc_line_t;
endpackage

/* tb/ilc_rx_line_model.sv */
// Far-end line equipment: sends a repeating loop code on the receive line
`timescale 1ns/10ps
module ilc_rx_line_model (
    input wire logic clock_in,
    input wire logic run_in,
    input wire logic [15:0] pat_in,
    input wire logic [4:0] len_in,
    input wire logic insert_in,
    output ilc_pkg::ilc_line_t rx_line_out
);
    int bitn;
    int ph;
    logic tog;
    initial rx_line_out = '0;
    // One line bit every second clock; data toggles between strobes so stale
    // values are never mistaken for a bit
    always @(posedge clock_in) begin
        if (!run_in) begin
            rx_line_out.en <= 1'b0;
            rx_line_out.fbit <= 1'b0;
            rx_line_out.data <= ~rx_line_out.data;
            ph = 0;
            bitn = 0;
            tog = 1'b0;
        end else if (!tog) begin
            rx_line_out.en <= 1'b1;
            if (bitn % 193 == 0) begin
                rx_line_out.fbit <= 1'b1;
                rx_line_out.data <= bitn[1];
                if (!insert_in) ph = (ph + 1) % len_in;
            end else begin
                rx_line_out.fbit <= 1'b0;
                // One bit in a hundred flipped, a 1e-2 error rate
                rx_line_out.data <= pat_in[15 - ph] ^ (bitn % 100 == 50);
                ph = (ph + 1) % len_in;
            end
            bitn++;
            tog = 1'b1;
        end else begin
            rx_line_out.en <= 1'b0;
            rx_line_out.fbit <= 1'b0;
            rx_line_out.data <= ~rx_line_out.data;
            tog = 1'b0;
        end
    end
endmodule

/* tb/inband_loop_code_gen_detect_tb_top.sv */
// Self-checking bench of the in-band loop code unit
`timescale 1ns/10ps
module inband_loop_code_gen_detect_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] adr = '0;
    logic [31:0] dwr = '0;
    logic [3:0] sel = 4'hf;
    logic ack, txo, up, dn, sp;
    logic [31:0] drd;
    ilc_pkg::ilc_line_t txl = '0;
    ilc_pkg::ilc_line_t rxl;
    logic m_run = 1'b0, m_ins = 1'b0;
    logic [15:0] m_pat = '0;
    logic [4:0] m_len = 5'h01;
    logic [7:0] r;
    logic [2:0] det;
    int failures = 0;
    int comparisons = 0;
    assign det = {sp, dn, up};
    always #5 clk = ~clk;
    ilc_loop_code #(.INTEG_CYCLES(200)) dut (.clock_in(clk), .nrst_in(nrst),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_dat_in(dwr), .wb_sel_in(sel), .wb_ack_out(ack), .wb_dat_out(drd),
        .tx_line_in(txl), .rx_line_in(rxl), .tx_data_out(txo),
        .loop_up_detected_out(up), .loop_down_detected_out(dn),
        .spare_code_detected_out(sp));
    ilc_rx_line_model far (.clock_in(clk), .run_in(m_run), .pat_in(m_pat),
        .len_in(m_len), .insert_in(m_ins), .rx_line_out(rxl));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb_acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dwr <= {24'h0, d};
        // Ack and read data are taken at the rising edge that shows ack high
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = drd[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) check("ack", 1, 0);
    endtask
    task automatic wb_write(input logic [7:0] idx, input logic [7:0] d);
        wb_acc(1'b1, idx, d);
    endtask
    task automatic tx_bit(input logic f, input logic d, input logic e);
        @(posedge clk);
        txl <= '{en: 1'b1, fbit: f, data: d};
        @(posedge clk);
        txl <= '{en: 1'b0, fbit: 1'b0, data: ~d};
        @(negedge clk);
        check("tx_bit", e, txo);
    endtask
    // Loads a code, sends len+4 bits with one framing slot at fat, then stops
    task automatic tx_run(input logic [7:0] ib, input logic [7:0] ccr, input logic [15:0] pat,
        input int len, input int fat);
        logic pb;
        wb_write(ilc_pkg::IDX_INBAND_CTRL, ib);
        wb_write(ilc_pkg::IDX_TCD_HI, pat[15:8]);
        wb_write(ilc_pkg::IDX_TCD_LO, pat[7:0]);
        wb_write(ilc_pkg::IDX_CCR1, ccr);
        for (int i = 0; i < len + 4; i++) begin
            pb = pat[15 - (i % len)];
            if (i == fat) tx_bit(1'b1, ~pb, ccr[2] ? pb : ~pb);
            else tx_bit(1'b0, ~pb, pb);
        end
        wb_write(ilc_pkg::IDX_CCR1, 8'h02);
    endtask
    task automatic det_run(input int k, input logic [7:0] hi_i, input logic [15:0] pat,
        input logic [4:0] len, input logic ins);
        int n;
        wb_write(hi_i, pat[15:8]);
        wb_write(hi_i + 8'h01, pat[7:0]);
        m_pat <= pat;
        m_len <= len;
        m_ins <= ins;
        m_run <= 1'b1;
        n = 0;
        while (det[k] !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        check("det", 16'h1 << k, {13'h0, det});
        check("not_early", 1, n >= 400);
        wb_acc(1'b0, ilc_pkg::IDX_STATUS3, 8'h00);
        check("sr3", 16'h20 << k, r);
        // Poll again a while later: a code that is still sent stays reported
        repeat (300) @(posedge clk);
        wb_acc(1'b0, ilc_pkg::IDX_STATUS3, 8'h00);
        check("sr3_held", 16'h20 << k, r);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 8'hb6; i <= 8'hc1; i++) begin
            wb_acc(1'b0, i[7:0], 8'h00);
            check("reset_val", 8'h00, r);
        end
        for (int i = 8'hb6; i <= 8'hc0; i++) begin
            wb_write(i[7:0], i[7:0] ^ 8'h5a);
            wb_acc(1'b0, i[7:0], 8'h00);
            check("rw", i[7:0] ^ 8'h5a, r);
        end
        wb_write(ilc_pkg::IDX_CCR1, 8'h00);
        wb_write(ilc_pkg::IDX_STATUS3, 8'hff);
        wb_acc(1'b0, ilc_pkg::IDX_STATUS3, 8'h00);
        check("sr3_ro", 8'h00, r);
        wb_write(8'h10, 8'hff);
        wb_acc(1'b0, 8'h10, 8'h00);
        check("unmapped", 8'h00, r);
        $display("test registers done");
        // Loop enabled but channel not in T1: line passes through
        wb_write(ilc_pkg::IDX_INBAND_CTRL, 8'hc0);
        wb_write(ilc_pkg::IDX_CCR1, 8'h01);
        tx_bit(1'b0, 1'b1, 1'b1);
        tx_bit(1'b0, 1'b0, 1'b0);
        tx_run(8'hc0, 8'h03, 16'ha53c, 16, 17);
        tx_run(8'h00, 8'h07, 16'h8000, 5, 7);
        tx_run(8'h40, 8'h03, 16'hb4b4, 6, 3);
        tx_run(8'h80, 8'h07, 16'hd200, 7, 9);
        tx_bit(1'b0, 1'b1, 1'b1);
        tx_bit(1'b0, 1'b0, 1'b0);
        $display("test generator done");
        wb_write(ilc_pkg::IDX_INBAND_CTRL, 8'h27);
        wb_write(ilc_pkg::IDX_SP_CTRL, 8'h02);
        det_run(0, ilc_pkg::IDX_UP_HI, 16'h8000, 5'd5, 1'b1);
        wb_write(ilc_pkg::IDX_UP_LO, 8'h00);
        @(negedge clk);
        check("restart", 8'h00, {5'h0, det});
        det_run(1, ilc_pkg::IDX_DN_HI, 16'h12ab, 5'd16, 1'b0);
        wb_write(ilc_pkg::IDX_CCR1, 8'h00);
        @(negedge clk);
        check("t1_off", 8'h00, {5'h0, det});
        wb_write(ilc_pkg::IDX_CCR1, 8'h02);
        det_run(2, ilc_pkg::IDX_SP_HI, 16'hc000, 5'd3, 1'b1);
        wb_write(ilc_pkg::IDX_SP_LO, 8'h00);
        @(negedge clk);
        check("restart", 8'h00, {5'h0, det});
        m_run <= 1'b0;
        $display("test detectors done");
        report_and_stop;
    end
endmodule
